// *** src/prog_seq_map.svh ***
`ifndef PROG_SEQ_MAP_SVH
`define PROG_SEQ_MAP_SVH
// program space size and width
`define PC_WIDTH       9
`define PROG_WORDS     512
// vectors
`define VEC_RESET      9'h000
`define VEC_SOFT_INT   9'h001
`define VEC_HW_INT     9'h008
// reserved tail and rolling-code words
`define RSV_LO         9'h1FE
`define RSV_HI         9'h1FF
`define ROLL_LO        9'h00E
`define ROLL_HI        9'h00F
// return stack depth and pointer width
`define STACK_DEPTH    4
`define STACK_PTR_W    3
// instruction cycle counts
`define CYC_SINGLE     2'h1
`define CYC_BRANCH     2'h2
`endif

// *** src/prog_seq_pkg.sv ***
package prog_seq_pkg;
	// operation requested by the decoder for the current instruction
	typedef enum logic [3:0] {
		OP_NEXT,        // plain instruction, pc advances
		OP_SKIP,        // skip next instruction (two cycles)
		OP_JUMP,        // 9-bit target jump
		OP_CALL,        // short call, 256-word reach
		OP_JUMP_ACC,    // jump via accumulator
		OP_CALL_ACC,    // call via accumulator
		OP_LONG_JUMP,   // full-range jump
		OP_LONG_CALL,   // full-range call
		OP_RET,         // plain return
		OP_RET_LIT,     // return with literal
		OP_RET_INT,     // return from interrupt
		OP_SOFT_INT,    // software interrupt
		OP_PCL_WRITE    // direct write of pc low byte
	} seq_op_t;
	// operating mode as seen by the wake logic
	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_STANDBY,
		MODE_HALT
	} run_mode_t;
	// sequencer state
	typedef enum logic [1:0] {
		ST_EXEC,
		ST_FLUSH,
		ST_SLEEP
	} seq_state_t;
endpackage : prog_seq_pkg

// *** src/sync_two_ff.sv ***
`timescale 1ns/1ns
// two-stage synchroniser for one asynchronous pin
module sync_two_ff (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic asyncIn,
	output logic      syncOut
);
	logic stage1Reg; // first stage, read only by the second

	// resolve metastability over two edges
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			// pins idle high, so reset to idle: no false edge on release
			stage1Reg <= 1'b1;
			syncOut   <= 1'b1;
		end else begin
			stage1Reg <= asyncIn;
			syncOut   <= stage1Reg;
		end
	end
endmodule : sync_two_ff

// *** src/return_stack.sv ***
`timescale 1ns/1ns
`include "prog_seq_map.svh"
// four-entry return stack held in flip-flops, index addressed
module return_stack (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    push,
	input  wire logic                    pop,
	input  wire logic [`PC_WIDTH-1:0]    pushData,
	output logic      [`PC_WIDTH-1:0]    topData,
	output logic      [`STACK_PTR_W-1:0] depth
);
	logic [`PC_WIDTH-1:0]    entryReg [`STACK_DEPTH]; // storage
	logic [1:0]              topIdx;                  // slot of top
	logic [1:0]              wrIdx;                   // slot to write

	// slot index wraps modulo four; on overflow depth stays four and the push overwrites slot 0
	assign topIdx  = depth[1:0] - 2'h1;
	assign wrIdx   = depth[1:0];
	assign topData = entryReg[topIdx];

	// storage writes on push; entries are not cleared by reset
	always_ff @(posedge clk) begin
		if (push) begin
			entryReg[wrIdx] <= pushData; // RULE5
		end
	end

	// fill count saturates at four, empties to zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			depth <= '0;
		end else if (push && !pop) begin
			if (depth != 3'(`STACK_DEPTH)) begin
				depth <= depth + 3'h1; // RULE7
			end
		end else if (pop && !push) begin
			if (depth != 3'h0) begin
				depth <= depth - 3'h1; // RULE6
			end
		end
	end
endmodule : return_stack

// *** src/program_sequencer_stack.sv ***
`timescale 1ns/1ns
`include "prog_seq_map.svh"
// How it works
// RULE1: nine-bit pc spans 512 words
// RULE2: power-on fetch starts at 0x000
// RULE3: software interrupt goes to 0x001
// RULE4: every hardware interrupt goes to 0x008
// RULE5: calls and interrupts push next address
// RULE6: all three returns pop into pc
// RULE7: return stack holds four entries
// RULE8: short call, accumulator forms reach 256
// RULE9: plain jump reaches all 512 words
// RULE10: long call and jump reach anywhere
// RULE11: one cycle, branches and skips two
// RULE12: firmware avoids reserved words 0x1FE-0x1FF
// RULE13: rolling-code words run as normal code
// RULE14: bit0 interrupt needs select and enable
// RULE15: low reset pin resets whole device
// RULE16: standby wakes on timer, change, external
// RULE17: halt wakes on change or external only
// RULE18: pc low byte advances after each instruction
// RULE19: pc bit 8 loads only via high buffer
// RULE20: interrupt taken after instruction, pushes next
module program_sequencer_stack
	import prog_seq_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire seq_op_t              op,
	input  wire logic [8:0]           jumpTarget,
	input  wire logic [7:0]           shortTarget,
	input  wire logic [7:0]           accValue,
	input  wire logic [7:0]           pcLowWrite,
	input  wire logic                 pcHighBufferBit,
	input  wire logic                 skipTaken,
	input  wire run_mode_t            modeReq,
	input  wire logic                 port_b_bit0,
	input  wire logic                 port_b_bit3,
	input  wire logic                 resetPinEnable,
	input  wire logic                 ext_int_select,
	input  wire logic                 ext_int_enable,
	input  wire logic                 globalIntEnable,
	input  wire logic                 timerOverflowIrq,
	input  wire logic                 portChangeIrq,
	output logic      [`PC_WIDTH-1:0] pcOut,
	output logic      [7:0]           pc_low_byte,
	output logic                      fetchValid,
	output logic                      intAckPulse,
	output logic                      extIntPending,
	output logic                      wakePulse,
	output logic                      sleeping,
	output logic                      deviceReset_n,
	output logic      [2:0]           stackDepth
);
	// synchronised pins
	logic bit0Sync;       // port b bit 0 after two flops
	logic bit3Sync;       // port b bit 3 after two flops
	logic bit0Prev_reg;   // last sampled bit 0 for edge detect
	// reset combination
	logic coreRst_n;      // power-on reset and pin reset together
	// sequencer state
	seq_state_t stateReg; // exec, flush or sleep
	logic [`PC_WIDTH-1:0] pcReg;  // program counter
	logic [`PC_WIDTH-1:0] pcNext; // next program counter
	logic [`PC_WIDTH-1:0] pcInc;  // address of next instruction
	logic extEdge;        // falling edge on bit 0
	logic hwIrq;          // any hardware interrupt request
	logic takeIrq;        // interrupt taken at this boundary
	logic doPush;         // stack push this cycle
	logic doPop;          // stack pop this cycle
	logic twoCycle;       // instruction needs a flush cycle
	logic wakeEvent;      // event that ends sleep in current mode
	run_mode_t sleepMode_reg; // mode entered when sleeping
	logic [`PC_WIDTH-1:0] stackTop; // top of return stack
	logic [1:0] cycleCount_reg;     // cycles spent on instruction

	sync_two_ff uSync0 (
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn (port_b_bit0),
		.syncOut (bit0Sync)
	);

	sync_two_ff uSync3 (
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn (port_b_bit3),
		.syncOut (bit3Sync)
	);

	// pin reset only counts when bit 3 is configured as reset
	assign coreRst_n = rst_n && !(resetPinEnable && !bit3Sync); // RULE15

	// reset output registered so the rest of the chip follows
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			deviceReset_n <= 1'b0;
		end else begin
			deviceReset_n <= coreRst_n; // RULE15
		end
	end

	// edge detect on bit 0, history tracks the pin through a pin reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bit0Prev_reg <= 1'b1;
		end else begin
			bit0Prev_reg <= bit0Sync;
		end
	end

	// external interrupt active only with select and enable both set
	assign extEdge = ext_int_select && ext_int_enable
		&& bit0Prev_reg && !bit0Sync; // RULE14

	// pending external flag, set wins over acknowledge
	always_ff @(posedge clk) begin
		if (!coreRst_n) begin
			extIntPending <= 1'b0;
		end else if (extEdge) begin
			extIntPending <= 1'b1; // RULE14
		end else if (intAckPulse) begin
			extIntPending <= 1'b0;
		end
	end

	assign hwIrq = globalIntEnable
		&& (extIntPending || timerOverflowIrq || portChangeIrq);

	// wake sources depend on which low-power mode was entered
	always_comb begin
		unique case (sleepMode_reg)
			MODE_STANDBY: wakeEvent = timerOverflowIrq || portChangeIrq
				|| extIntPending || extEdge; // RULE16
			MODE_HALT:    wakeEvent = portChangeIrq
				|| extIntPending || extEdge; // RULE17
			default:      wakeEvent = 1'b1;
		endcase
	end

	assign pcInc = pcReg + 9'h001; // RULE18
	assign twoCycle = (op inside {OP_JUMP, OP_CALL, OP_JUMP_ACC,
		OP_CALL_ACC, OP_LONG_JUMP, OP_LONG_CALL, OP_RET, OP_RET_LIT,
		OP_RET_INT, OP_SOFT_INT, OP_PCL_WRITE})
		|| (op == OP_SKIP && skipTaken); // RULE11
	// interrupts wait for the instruction boundary
	assign takeIrq = (stateReg == ST_EXEC) && hwIrq
		&& (cycleCount_reg == 2'h0); // RULE20
	assign doPush = (stateReg == ST_EXEC) && (takeIrq
		|| (!takeIrq && op inside {OP_CALL, OP_CALL_ACC,
		OP_LONG_CALL, OP_SOFT_INT})); // RULE5
	assign doPop = (stateReg == ST_EXEC) && !takeIrq
		&& (op inside {OP_RET, OP_RET_LIT, OP_RET_INT}); // RULE6

	// next pc selection by instruction class
	always_comb begin
		pcNext = pcReg;
		if (stateReg == ST_EXEC) begin
			if (takeIrq) begin
				pcNext = `VEC_HW_INT; // RULE4
			end else begin
				unique case (op)
					OP_NEXT:      pcNext = pcInc; // RULE13
					OP_SKIP:      pcNext = skipTaken ? pcReg + 9'h002
						: pcInc;
					OP_JUMP:      pcNext = jumpTarget; // RULE9
					OP_CALL:      pcNext = {1'b0, shortTarget}; // RULE8
					OP_JUMP_ACC:  pcNext = {1'b0, accValue}; // RULE8
					OP_CALL_ACC:  pcNext = {1'b0, accValue}; // RULE8
					OP_LONG_JUMP: pcNext = jumpTarget; // RULE10
					OP_LONG_CALL: pcNext = jumpTarget; // RULE10
					OP_RET:       pcNext = stackTop; // RULE6
					OP_RET_LIT:   pcNext = stackTop; // RULE6
					OP_RET_INT:   pcNext = stackTop; // RULE6
					OP_SOFT_INT:  pcNext = `VEC_SOFT_INT; // RULE3
					OP_PCL_WRITE: pcNext = {pcHighBufferBit,
						pcLowWrite}; // RULE19
					default:      pcNext = pcInc;
				endcase
			end
		end
	end

	// program counter, starts at reset vector
	always_ff @(posedge clk) begin
		if (!coreRst_n) begin
			pcReg <= `VEC_RESET; // RULE2
		end else begin
			pcReg <= pcNext; // RULE1
		end
	end

	// cycle counter marks the flush cycle of two-cycle instructions
	always_ff @(posedge clk) begin
		if (!coreRst_n) begin
			cycleCount_reg <= 2'h0;
		end else if (stateReg == ST_EXEC && !takeIrq && twoCycle) begin
			cycleCount_reg <= `CYC_SINGLE; // RULE11
		end else begin
			cycleCount_reg <= 2'h0;
		end
	end

	// state machine: execute, flush, sleep
	always_ff @(posedge clk) begin
		if (!coreRst_n) begin
			stateReg      <= ST_EXEC;
			sleepMode_reg <= MODE_RUN;
		end else begin
			unique case (stateReg)
				ST_EXEC: begin
					if (takeIrq || twoCycle) begin
						stateReg <= ST_FLUSH; // RULE11
					end else if (modeReq != MODE_RUN) begin
						stateReg      <= ST_SLEEP;
						sleepMode_reg <= modeReq;
					end
				end
				ST_FLUSH: stateReg <= ST_EXEC;
				ST_SLEEP: begin
					if (wakeEvent) begin
						stateReg      <= ST_EXEC; // RULE16
						sleepMode_reg <= MODE_RUN;
					end
				end
			endcase
		end
	end

	return_stack uStack (
		.clk      (clk),
		.rst_n    (coreRst_n),
		.push     (doPush),
		.pop      (doPop),
		.pushData (takeIrq ? pcReg : pcInc), // RULE20
		.topData  (stackTop),
		.depth    (stackDepth)
	);

	// registered status outputs
	always_ff @(posedge clk) begin
		if (!coreRst_n) begin
			pcOut       <= `VEC_RESET;
			pc_low_byte <= 8'h00;
			fetchValid  <= 1'b0;
			intAckPulse <= 1'b0;
			wakePulse   <= 1'b0;
			sleeping    <= 1'b0;
		end else begin
			pcOut       <= pcNext;
			pc_low_byte <= pcNext[7:0]; // RULE18
			fetchValid  <= (stateReg != ST_SLEEP);
			intAckPulse <= takeIrq; // RULE4
			wakePulse   <= (stateReg == ST_SLEEP) && wakeEvent;
			sleeping    <= (stateReg == ST_SLEEP) && !wakeEvent;
		end
	end

	// reset vector after release
	property p_reset_vector;
		@(posedge clk) $rose(coreRst_n) |-> pcReg == `VEC_RESET;
	endproperty
	a_reset_vector: assert property (p_reset_vector) // RULE2
		else $error("pc not at reset vector");

	property p_hw_vector;
		@(posedge clk) disable iff (!coreRst_n)
		takeIrq |=> pcReg == `VEC_HW_INT;
	endproperty
	a_hw_vector: assert property (p_hw_vector) // RULE4
		else $error("hardware interrupt vector wrong");

	property p_soft_vector;
		@(posedge clk) disable iff (!coreRst_n)
		(doPush && !takeIrq && op == OP_SOFT_INT)
		|=> pcReg == `VEC_SOFT_INT;
	endproperty
	a_soft_vector: assert property (p_soft_vector) // RULE3
		else $error("software interrupt vector wrong");

	property p_push_next;
		@(posedge clk) disable iff (!coreRst_n)
		(doPush && !takeIrq && stackDepth < 3'h4)
		|=> stackTop == $past(pcInc);
	endproperty
	a_push_next: assert property (p_push_next) // RULE5
		else $error("pushed address not next instruction");

	property p_pop_return;
		@(posedge clk) disable iff (!coreRst_n)
		doPop |=> pcReg == $past(stackTop);
	endproperty
	a_pop_return: assert property (p_pop_return) // RULE6
		else $error("return did not load stack top");

	property p_depth_max;
		@(posedge clk) disable iff (!coreRst_n)
		stackDepth <= 3'h4;
	endproperty
	a_depth_max: assert property (p_depth_max) // RULE7
		else $error("stack depth above four");

	sequence s_branch;
		stateReg == ST_EXEC && !takeIrq && twoCycle;
	endsequence
	property p_two_cycle;
		@(posedge clk) disable iff (!coreRst_n)
		s_branch |=> stateReg == ST_FLUSH ##1 stateReg != ST_FLUSH;
	endproperty
	a_two_cycle: assert property (p_two_cycle) // RULE11
		else $error("branch not two cycles");

	property p_halt_timer;
		@(posedge clk) disable iff (!coreRst_n)
		(stateReg == ST_SLEEP && sleepMode_reg == MODE_HALT
		&& !portChangeIrq && !extIntPending && !extEdge)
		|=> stateReg == ST_SLEEP;
	endproperty
	a_halt_timer: assert property (p_halt_timer) // RULE17
		else $error("halt woke on timer");

	property p_ext_gate;
		@(posedge clk) disable iff (!coreRst_n)
		!(ext_int_select && ext_int_enable) |-> !extEdge;
	endproperty
	a_ext_gate: assert property (p_ext_gate) // RULE14
		else $error("external interrupt without enable");
endmodule : program_sequencer_stack

// *** tb/irq_source_model.sv ***
`timescale 1ns/1ns
// event sources: each request is a level held until the block services it or the bench withdraws it
module irq_source_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic raiseTimer,  // one-cycle raise from the bench
	input  wire logic raisePort,   // one-cycle raise from the bench
	input  wire logic dropAll,     // withdraw requests never serviced
	input  wire logic intAckPulse, // service acknowledge from the block
	output logic      timerOverflowIrq,
	output logic      portChangeIrq
);
	// timer overflow request, cleared only by reset, service or withdrawal
	always_ff @(posedge clk) begin
		if (!rst_n || dropAll || intAckPulse) begin
			timerOverflowIrq <= 1'b0;
		end else if (raiseTimer) begin
			timerOverflowIrq <= 1'b1;
		end
	end
	// port change request, same holding behaviour
	always_ff @(posedge clk) begin
		if (!rst_n || dropAll || intAckPulse) begin
			portChangeIrq <= 1'b0;
		end else if (raisePort) begin
			portChangeIrq <= 1'b1;
		end
	end
endmodule : irq_source_model

// *** tb/test_program_sequencer_stack.sv ***
`timescale 1ns/1ns
// bench: drives instruction classes and pins, judges pc and flags
module test_program_sequencer_stack
	import prog_seq_pkg::*;
;
	logic      clk, rst_n, pcHighBufferBit, skipTaken;
	seq_op_t   op;
	run_mode_t modeReq;
	logic      [8:0] jumpTarget, pcOut, retPc;
	logic      [7:0] shortTarget, accValue, pcLowWrite, pc_low_byte;
	logic      port_b_bit0, port_b_bit3, resetPinEnable;
	logic      ext_int_select, ext_int_enable, globalIntEnable;
	logic      timerOverflowIrq, portChangeIrq;
	logic      raiseTimer, raisePort, dropAll;
	logic      fetchValid, intAckPulse, extIntPending;
	logic      wakePulse, sleeping, deviceReset_n;
	logic      [2:0] stackDepth;
	logic      [4:0] flags;   // flags watched by bounded waits
	int        errors, check_count;
	assign flags = {intAckPulse, deviceReset_n, extIntPending, wakePulse,
		sleeping};
	// event sources on the far side
	irq_source_model irq_source_model_i (.clk(clk), .rst_n(rst_n),
		.raiseTimer(raiseTimer), .raisePort(raisePort),
		.dropAll(dropAll), .intAckPulse(intAckPulse),
		.timerOverflowIrq(timerOverflowIrq),
		.portChangeIrq(portChangeIrq));
	program_sequencer_stack program_sequencer_stack_i (.clk(clk),
		.rst_n(rst_n), .op(op), .jumpTarget(jumpTarget),
		.shortTarget(shortTarget), .accValue(accValue),
		.pcLowWrite(pcLowWrite), .pcHighBufferBit(pcHighBufferBit),
		.skipTaken(skipTaken), .modeReq(modeReq),
		.port_b_bit0(port_b_bit0), .port_b_bit3(port_b_bit3),
		.resetPinEnable(resetPinEnable), .ext_int_select(ext_int_select),
		.ext_int_enable(ext_int_enable),
		.globalIntEnable(globalIntEnable),
		.timerOverflowIrq(timerOverflowIrq),
		.portChangeIrq(portChangeIrq), .pcOut(pcOut),
		.pc_low_byte(pc_low_byte), .fetchValid(fetchValid),
		.intAckPulse(intAckPulse), .extIntPending(extIntPending),
		.wakePulse(wakePulse), .sleeping(sleeping),
		.deviceReset_n(deviceReset_n), .stackDepth(stackDepth));
	// 250 MHz clock
	always #2 clk = ~clk;
	// verdict and end of run
	task report_and_stop;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop
	// compare a vector result
	task checkVec(input string what, input logic [8:0] e, input logic [8:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask : checkVec
	// compare a single flag
	task checkFlag(input string what, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %b seen %b", what, e, g);
		end
	endtask : checkFlag
	// pass edges; inputs then change 1 ns after the edge
	task tick(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
		end
	endtask : tick
	// bounded wait for a watched flag to reach a level
	task waitFlag(input int which, input logic level, input int limit);
		for (int k = 0; k < limit; k++) begin
			tick(1);
			if (flags[which] === level) return;
		end
		errors++;
		$display("[FAIL] wait %0d expected %b seen timeout", which, level);
		report_and_stop();
	endtask : waitFlag
	// one-cycle strobe to the source model {drop, port, timer}
	task pulse(input logic [2:0] which);
		{dropAll, raisePort, raiseTimer} = which;
		tick(1);
		{dropAll, raisePort, raiseTimer} = 3'h0;
	endtask : pulse
	// present one op; two-cycle ops keep pc through the flush cycle
	task doOp(input seq_op_t o, input logic twoCyc, input logic [8:0] e);
		op = o;
		tick(1);
		checkVec("pcOut", e, pcOut);
		if (twoCyc) begin
			op = OP_NEXT;
			tick(1);
			checkVec("pcOut held", e, pcOut);
		end
	endtask : doOp
	// straight-line flow, skips and every jump form
	task scFlow;
		checkVec("pcOut", 9'h000, pcOut);
		doOp(OP_NEXT, 1'b0, 9'h001);
		doOp(OP_NEXT, 1'b0, 9'h002);
		doOp(OP_SKIP, 1'b0, 9'h003);
		skipTaken = 1'b1;
		doOp(OP_SKIP, 1'b1, 9'h005);
		jumpTarget = 9'h155;
		doOp(OP_JUMP, 1'b1, 9'h155);
		jumpTarget = 9'h1FD; // kept below the reserved words
		doOp(OP_LONG_JUMP, 1'b1, 9'h1FD);
		jumpTarget = 9'h00E;
		doOp(OP_LONG_JUMP, 1'b1, 9'h00E);
		doOp(OP_NEXT, 1'b0, 9'h00F);
		doOp(OP_NEXT, 1'b0, 9'h010);
		accValue = 8'hAB;
		doOp(OP_JUMP_ACC, 1'b1, 9'h0AB);
		pcHighBufferBit = 1'b1;
		pcLowWrite = 8'h34;
		doOp(OP_PCL_WRITE, 1'b1, 9'h134);
		checkVec("pc_low_byte", 9'h034, {1'b0, pc_low_byte});
		doOp(OP_SOFT_INT, 1'b1, 9'h001);
		checkVec("stackDepth", 9'h001, {6'h00, stackDepth});
		doOp(OP_RET, 1'b1, 9'h135);
	endtask : scFlow
	// four nested calls of mixed forms, unwound by all return forms
	task automatic scStack;
		seq_op_t    calls[4] = '{OP_CALL, OP_CALL_ACC, OP_LONG_CALL, OP_CALL};
		seq_op_t    rets[4]  = '{OP_RET, OP_RET_LIT, OP_RET_INT, OP_RET};
		logic [8:0] tgt;
		jumpTarget = 9'h000;
		doOp(OP_LONG_JUMP, 1'b1, 9'h000);
		for (int i = 0; i < 4; i++) begin
			tgt = 9'((i + 1) * 16);
			jumpTarget = tgt;
			shortTarget = tgt[7:0];
			accValue = tgt[7:0];
			doOp(calls[i], 1'b1, tgt);
			checkVec("stackDepth", 9'(i + 1), {6'h00, stackDepth});
		end
		for (int i = 0; i < 4; i++) begin
			doOp(rets[i], 1'b1, 9'((3 - i) * 16 + 1));
		end
		checkVec("stackDepth", 9'h000, {6'h00, stackDepth});
	endtask : scStack
	// timer and port change requests share one vector
	task scHwIrq;
		globalIntEnable = 1'b1;
		for (int s = 0; s < 2; s++) begin
			{raisePort, raiseTimer} = 2'(1 << s);
			tick(1);
			retPc = pcOut;
			{raisePort, raiseTimer} = 2'h0;
			tick(1);
			checkFlag("intAckPulse", 1'b1, intAckPulse);
			checkVec("pcOut", 9'h008, pcOut);
			tick(1);
			checkVec("pcOut held", 9'h008, pcOut);
			doOp(OP_RET_INT, 1'b1, retPc);
		end
		globalIntEnable = 1'b0;
	endtask : scHwIrq
	// falling edge on bit 0 counts only with select and enable set
	task scExtInt;
		ext_int_enable = 1'b1;
		port_b_bit0 = 1'b0;
		tick(6);
		checkFlag("extIntPending", 1'b0, extIntPending);
		port_b_bit0 = 1'b1;
		ext_int_select = 1'b1;
		tick(4);
		port_b_bit0 = 1'b0;
		waitFlag(2, 1'b1, 8);
		checkFlag("extIntPending", 1'b1, extIntPending);
		globalIntEnable = 1'b1;
		waitFlag(4, 1'b1, 4);
		checkVec("pcOut", 9'h008, pcOut);
		tick(1);
		checkFlag("extIntPending", 1'b0, extIntPending);
		globalIntEnable = 1'b0;
		port_b_bit0 = 1'b1;
	endtask : scExtInt
	// standby wakes on timer; halt ignores timer, wakes on port change
	task scSleep;
		modeReq = MODE_STANDBY;
		waitFlag(0, 1'b1, 6);
		modeReq = MODE_RUN;
		pulse(3'h1);
		waitFlag(1, 1'b1, 8);
		checkFlag("wakePulse", 1'b1, wakePulse);
		pulse(3'h4);
		modeReq = MODE_STANDBY;
		waitFlag(0, 1'b1, 6);
		modeReq = MODE_RUN;
		pulse(3'h2);
		waitFlag(1, 1'b1, 8);
		checkFlag("wakePulse", 1'b1, wakePulse);
		pulse(3'h4);
		modeReq = MODE_HALT;
		waitFlag(0, 1'b1, 6);
		modeReq = MODE_RUN;
		pulse(3'h1);
		repeat (12) begin
			checkFlag("wakePulse", 1'b0, wakePulse);
			tick(1);
		end
		checkFlag("sleeping", 1'b1, sleeping);
		checkFlag("fetchValid", 1'b0, fetchValid);
		pulse(3'h4);
		pulse(3'h2);
		waitFlag(1, 1'b1, 8);
		checkFlag("wakePulse", 1'b1, wakePulse);
		pulse(3'h4);
		// halt again, woken by a falling edge on bit 0
		modeReq = MODE_HALT;
		waitFlag(0, 1'b1, 6);
		modeReq = MODE_RUN;
		port_b_bit0 = 1'b0;
		waitFlag(1, 1'b1, 8);
		checkFlag("wakePulse", 1'b1, wakePulse);
		checkFlag("extIntPending", 1'b1, extIntPending);
		port_b_bit0 = 1'b1;
	endtask : scSleep
	// low bit 3 resets the device only when it serves as reset pin
	task scPinReset;
		port_b_bit3 = 1'b0;
		tick(6);
		checkFlag("deviceReset_n", 1'b1, deviceReset_n);
		resetPinEnable = 1'b1;
		waitFlag(3, 1'b0, 6);
		checkVec("pcOut", 9'h000, pcOut);
		checkVec("stackDepth", 9'h000, {6'h00, stackDepth});
		port_b_bit3 = 1'b1;
		waitFlag(3, 1'b1, 6);
	endtask : scPinReset
	// main sequence
	initial begin
		{clk, rst_n, pcHighBufferBit, skipTaken} = 4'h0;
		{raiseTimer, raisePort, dropAll} = 3'h0;
		{resetPinEnable, ext_int_select, ext_int_enable} = 3'h0;
		globalIntEnable = 1'b0;
		{port_b_bit0, port_b_bit3} = 2'h3;
		op = OP_NEXT;
		modeReq = MODE_RUN;
		jumpTarget = 9'h000;
		{shortTarget, accValue, pcLowWrite} = 24'h000000;
		errors = 0;
		check_count = 0;
		tick(10);
		rst_n = 1'b1;
		scFlow();
		scStack();
		scHwIrq();
		scExtInt();
		scSleep();
		scPinReset();
		report_and_stop();
	end
endmodule : test_program_sequencer_stack
